// file: design/abssc_top.sv
// Bit-rate dividers, special-character registers, compare and send for one channel.
//
// Local design decision: the Avalon-MM register port.

// Contract
// - Receive counter preloads the 16-bit value from receive high and low bytes.
// - Receive 16x tick period equals receive divisor times clock period.
// - Reset clears all receive and transmit divisor bytes to zero.
// - Transmit counter preloads its own 16-bit value from transmit high and low.
// - Transmit 16x tick period equals transmit divisor times clock period.
// - Each received character is compared with all four; matches go in status.
// - With double compare, status match waits until both pair characters match.
// - Send one sends character one, or one then three in two-character mode.
// - Send two sends character two, or two then four in two-character mode.
// - Send three sends the third special character.
// - Character one is Xon, or Xon first half with three second.
// - Character two is Xoff, or first half of the Xoff pair.
// - Character four is the second half of the Xoff pair.
module abssc_top
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [abssc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Bit-rate ticks
    output logic rx_tick_o,
    output logic tx_tick_o,
    // Received characters and their status entries
    input wire logic [7:0] rx_char_i,
    input wire logic rx_char_valid_i,
    output logic rx_stat_valid_o,
    output logic [7:0] rx_stat_char_o,
    output logic [3:0] rx_stat_match_o,
    // Special characters to the transmitter
    output logic [7:0] tx_char_o,
    output logic tx_char_valid_o,
    input wire logic tx_char_ready_i
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic reg_hit(input logic [abssc_pkg::ADDR_W-1:0] addr,
                                     input logic [7:0] idx);
        reg_hit = (addr == {idx, 2'b00});
    endfunction : reg_hit

    function automatic logic [3:0] char_match(input logic [7:0] c,
                                              input logic [7:0] s1,
                                              input logic [7:0] s2,
                                              input logic [7:0] s3,
                                              input logic [7:0] s4);
        char_match = {c == s4, c == s3, c == s2, c == s1};
    endfunction : char_match

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] special_char_one_r;
    logic [7:0] special_char_two_r;
    logic [7:0] special_char_three_r;
    logic [7:0] special_char_four_r;
    logic [7:0] rx_divisor_high_r;
    logic [7:0] rx_divisor_low_r;
    logic [7:0] tx_divisor_high_r;
    logic [7:0] tx_divisor_low_r;
    logic [1:0] control_r;
    logic ack_r;
    logic [31:0] readdata_r;
    logic [31:0] readdata_nxt;
    logic wr_en;
    logic [7:0] wr_byte;
    logic [1:0] pend_r;
    logic [3:0] match_now;
    logic rx_stat_valid_r;
    logic [7:0] rx_stat_char_r;
    logic [3:0] rx_stat_match_r;
    abssc_pkg::abssc_tx_state_t tx_state_r;
    logic [7:0] tx_char_r;
    logic [7:0] tx_second_r;
    logic tx_has_second_r;
    logic cmd_wr;

    abssc_rate_if rx_rate ();
    abssc_rate_if tx_rate ();

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    // Every access waits exactly one cycle, then completes.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= (avs_read | avs_write) & ~ack_r;
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_en = avs_write & ack_r & avs_byteenable[0];
    assign wr_byte = avs_writedata[7:0];
    assign cmd_wr = wr_en && reg_hit(avs_address, abssc_pkg::IDX_COMMAND);

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_divisor_high_r <= abssc_pkg::RESET_BYTE;
            rx_divisor_low_r <= abssc_pkg::RESET_BYTE;
            tx_divisor_high_r <= abssc_pkg::RESET_BYTE;
            tx_divisor_low_r <= abssc_pkg::RESET_BYTE;
        end
        else if (wr_en)
        begin
            if (reg_hit(avs_address, abssc_pkg::IDX_RX_DIVISOR_HIGH))
                rx_divisor_high_r <= wr_byte;
            if (reg_hit(avs_address, abssc_pkg::IDX_RX_DIVISOR_LOW))
                rx_divisor_low_r <= wr_byte;
            if (reg_hit(avs_address, abssc_pkg::IDX_TX_DIVISOR_HIGH))
                tx_divisor_high_r <= wr_byte;
            if (reg_hit(avs_address, abssc_pkg::IDX_TX_DIVISOR_LOW))
                tx_divisor_low_r <= wr_byte;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            special_char_one_r <= abssc_pkg::RESET_BYTE;
            special_char_two_r <= abssc_pkg::RESET_BYTE;
            special_char_three_r <= abssc_pkg::RESET_BYTE;
            special_char_four_r <= abssc_pkg::RESET_BYTE;
            control_r <= 2'b00;
        end
        else if (wr_en)
        begin
            if (reg_hit(avs_address, abssc_pkg::IDX_SPECIAL_CHAR_ONE))
                special_char_one_r <= wr_byte;
            if (reg_hit(avs_address, abssc_pkg::IDX_SPECIAL_CHAR_TWO))
                special_char_two_r <= wr_byte;
            if (reg_hit(avs_address, abssc_pkg::IDX_SPECIAL_CHAR_THREE))
                special_char_three_r <= wr_byte;
            if (reg_hit(avs_address, abssc_pkg::IDX_SPECIAL_CHAR_FOUR))
                special_char_four_r <= wr_byte;
            if (reg_hit(avs_address, abssc_pkg::IDX_CONTROL))
                control_r <= wr_byte[1:0];
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    always_comb
    begin
        readdata_nxt = 32'h0000_0000;
        if (reg_hit(avs_address, abssc_pkg::IDX_SPECIAL_CHAR_ONE))
            readdata_nxt[7:0] = special_char_one_r;
        else if (reg_hit(avs_address, abssc_pkg::IDX_SPECIAL_CHAR_TWO))
            readdata_nxt[7:0] = special_char_two_r;
        else if (reg_hit(avs_address, abssc_pkg::IDX_SPECIAL_CHAR_THREE))
            readdata_nxt[7:0] = special_char_three_r;
        else if (reg_hit(avs_address, abssc_pkg::IDX_SPECIAL_CHAR_FOUR))
            readdata_nxt[7:0] = special_char_four_r;
        else if (reg_hit(avs_address, abssc_pkg::IDX_CONTROL))
            readdata_nxt[1:0] = control_r;
        else if (reg_hit(avs_address, abssc_pkg::IDX_STATUS))
        begin
            readdata_nxt[abssc_pkg::STAT_TX_BUSY] = (tx_state_r != abssc_pkg::ABSSC_TX_IDLE);
            readdata_nxt[abssc_pkg::STAT_XON_PENDING] = pend_r[0];
            readdata_nxt[abssc_pkg::STAT_XOFF_PENDING] = pend_r[1];
        end
        else if (reg_hit(avs_address, abssc_pkg::IDX_RX_DIVISOR_HIGH))
            readdata_nxt[7:0] = rx_divisor_high_r;
        else if (reg_hit(avs_address, abssc_pkg::IDX_RX_DIVISOR_LOW))
            readdata_nxt[7:0] = rx_divisor_low_r;
        else if (reg_hit(avs_address, abssc_pkg::IDX_TX_DIVISOR_HIGH))
            readdata_nxt[7:0] = tx_divisor_high_r;
        else if (reg_hit(avs_address, abssc_pkg::IDX_TX_DIVISOR_LOW))
            readdata_nxt[7:0] = tx_divisor_low_r;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            readdata_r <= 32'h0000_0000;
        else if (avs_read & ~ack_r)
            readdata_r <= readdata_nxt;
    end

    assign avs_readdata = readdata_r;

    // ----------------------------------------------------------------
    // Bit-rate generators
    // ----------------------------------------------------------------
    assign rx_rate.divisor = {rx_divisor_high_r, rx_divisor_low_r};
    assign tx_rate.divisor = {tx_divisor_high_r, tx_divisor_low_r};

    abssc_rate_gen u_rx_rate
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rate(rx_rate)
    );

    abssc_rate_gen u_tx_rate
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rate(tx_rate)
    );

    assign rx_tick_o = rx_rate.tick;
    assign tx_tick_o = tx_rate.tick;

    // ----------------------------------------------------------------
    // Receive compare
    // ----------------------------------------------------------------
    assign match_now = char_match(rx_char_i, special_char_one_r, special_char_two_r,
                                  special_char_three_r, special_char_four_r);

    // In pair mode a first half only arms a pending flag; the entry of
    // the second character carries the match of both halves.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend_r <= 2'b00;
            rx_stat_valid_r <= 1'b0;
            rx_stat_char_r <= 8'h00;
            rx_stat_match_r <= 4'h0;
        end
        else
        begin
            rx_stat_valid_r <= rx_char_valid_i;
            if (rx_char_valid_i)
            begin
                rx_stat_char_r <= rx_char_i;
                if (control_r[abssc_pkg::CTRL_DOUBLE_COMPARE])
                begin
                    pend_r <= {match_now[1], match_now[0]};
                    if (pend_r[0] && match_now[2])
                        rx_stat_match_r <= abssc_pkg::MATCH_XON_PAIR;
                    else if (pend_r[1] && match_now[3])
                        rx_stat_match_r <= abssc_pkg::MATCH_XOFF_PAIR;
                    else
                        rx_stat_match_r <= 4'h0;
                end
                else
                begin
                    pend_r <= 2'b00;
                    rx_stat_match_r <= match_now;
                end
            end
        end
    end

    assign rx_stat_valid_o = rx_stat_valid_r;
    assign rx_stat_char_o = rx_stat_char_r;
    assign rx_stat_match_o = rx_stat_match_r;

    // ----------------------------------------------------------------
    // Special-character send
    // ----------------------------------------------------------------
    // Commands written while a send is in progress are dropped.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_state_r <= abssc_pkg::ABSSC_TX_IDLE;
            tx_char_r <= 8'h00;
            tx_second_r <= 8'h00;
            tx_has_second_r <= 1'b0;
        end
        else
        begin
            unique case (tx_state_r)
                abssc_pkg::ABSSC_TX_IDLE:
                begin
                    if (cmd_wr && wr_byte == abssc_pkg::CMD_SEND_ONE)
                    begin
                        tx_char_r <= special_char_one_r;
                        tx_second_r <= special_char_three_r;
                        tx_has_second_r <= control_r[abssc_pkg::CTRL_TWO_CHAR_SEND];
                        tx_state_r <= abssc_pkg::ABSSC_TX_FIRST;
                    end
                    else if (cmd_wr && wr_byte == abssc_pkg::CMD_SEND_TWO)
                    begin
                        tx_char_r <= special_char_two_r;
                        tx_second_r <= special_char_four_r;
                        tx_has_second_r <= control_r[abssc_pkg::CTRL_TWO_CHAR_SEND];
                        tx_state_r <= abssc_pkg::ABSSC_TX_FIRST;
                    end
                    else if (cmd_wr && wr_byte == abssc_pkg::CMD_SEND_THREE)
                    begin
                        tx_char_r <= special_char_three_r;
                        tx_has_second_r <= 1'b0;
                        tx_state_r <= abssc_pkg::ABSSC_TX_FIRST;
                    end
                end
                abssc_pkg::ABSSC_TX_FIRST:
                begin
                    if (tx_char_ready_i)
                    begin
                        if (tx_has_second_r)
                        begin
                            tx_char_r <= tx_second_r;
                            tx_state_r <= abssc_pkg::ABSSC_TX_SECOND;
                        end
                        else
                            tx_state_r <= abssc_pkg::ABSSC_TX_IDLE;
                    end
                end
                abssc_pkg::ABSSC_TX_SECOND:
                begin
                    if (tx_char_ready_i)
                        tx_state_r <= abssc_pkg::ABSSC_TX_IDLE;
                end
                default:
                    tx_state_r <= abssc_pkg::ABSSC_TX_IDLE;
            endcase
        end
    end

    assign tx_char_o = tx_char_r;
    assign tx_char_valid_o = (tx_state_r != abssc_pkg::ABSSC_TX_IDLE);

endmodule : abssc_top

// file: pkg/abssc_pkg.sv
// Package with register map, field layout and state codes of the bit-rate and special-character block.
package abssc_pkg;

    // ----------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ----------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_SPECIAL_CHAR_ONE = 8'h12;
    localparam logic [7:0] IDX_SPECIAL_CHAR_TWO = 8'h14;
    localparam logic [7:0] IDX_SPECIAL_CHAR_THREE = 8'h16;
    localparam logic [7:0] IDX_SPECIAL_CHAR_FOUR = 8'h18;
    localparam logic [7:0] IDX_CONTROL = 8'h20;
    localparam logic [7:0] IDX_COMMAND = 8'h22;
    localparam logic [7:0] IDX_STATUS = 8'h24;
    localparam logic [7:0] IDX_RX_DIVISOR_HIGH = 8'h62;
    localparam logic [7:0] IDX_RX_DIVISOR_LOW = 8'h64;
    localparam logic [7:0] IDX_TX_DIVISOR_HIGH = 8'h72;
    localparam logic [7:0] IDX_TX_DIVISOR_LOW = 8'h74;

    // ----------------------------------------------------------------
    // Reset values and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int CTRL_TWO_CHAR_SEND = 0;
    localparam int CTRL_DOUBLE_COMPARE = 1;
    localparam int STAT_TX_BUSY = 0;
    localparam int STAT_XON_PENDING = 1;
    localparam int STAT_XOFF_PENDING = 2;
    localparam logic [7:0] CMD_SEND_ONE = 8'h01;
    localparam logic [7:0] CMD_SEND_TWO = 8'h02;
    localparam logic [7:0] CMD_SEND_THREE = 8'h03;
    localparam logic [3:0] MATCH_XON_PAIR = 4'h5;
    localparam logic [3:0] MATCH_XOFF_PAIR = 4'hA;

    // ----------------------------------------------------------------
    // Special-character transmit states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ABSSC_TX_IDLE = 3'b001,
        ABSSC_TX_FIRST = 3'b010,
        ABSSC_TX_SECOND = 3'b100
    } abssc_tx_state_t;

endpackage : abssc_pkg

// file: pkg/abssc_rate_if.sv
// Interface carrying a divisor to a bit-rate generator and its tick back.
interface abssc_rate_if;
    logic [15:0] divisor;
    logic tick;

    modport gen
    (
        input divisor,
        output tick
    );

    modport user
    (
        output divisor,
        input tick
    );
endinterface : abssc_rate_if

// file: design/abssc_rate_gen.sv
// Bit-rate generator producing a 16x tick whose period is the divisor in clocks.
module abssc_rate_gen
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Divisor in, tick out
    abssc_rate_if.gen rate
);

    logic [15:0] count_r;
    logic tick_r;

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    // A zero divisor parks the counter, so no tick is produced.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_r <= 16'h0000;
            tick_r <= 1'b0;
        end
        else if (rate.divisor == 16'h0000)
        begin
            count_r <= 16'h0000;
            tick_r <= 1'b0;
        end
        else if (count_r <= 16'h0001)
        begin
            count_r <= rate.divisor;
            tick_r <= (count_r == 16'h0001);
        end
        else
        begin
            count_r <= count_r - 16'h0001;
            tick_r <= 1'b0;
        end
    end

    assign rate.tick = tick_r;

endmodule : abssc_rate_gen

// file: verif/abssc_assertions.sv
// Checker of bus, tick, receive and send behaviour.
module abssc_checker
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic [abssc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Ticks
    input wire logic rx_tick_o,
    input wire logic tx_tick_o,
    // Receive path
    input wire logic [7:0] rx_char_i,
    input wire logic rx_char_valid_i,
    input wire logic rx_stat_valid_o,
    input wire logic [7:0] rx_stat_char_o,
    input wire logic [3:0] rx_stat_match_o,
    // Transmit path
    input wire logic [7:0] tx_char_o,
    input wire logic tx_char_valid_o,
    input wire logic tx_char_ready_i
);
    logic wr;
    logic [7:0] idx;
    logic [7:0] sc [4];
    logic [7:0] ctrl_r;
    logic [15:0] div_r [2];
    logic [1:0] chg_r;
    logic [1:0] wdiv;
    logic [1:0] tick;
    logic [3:0] mexp_r;
    int gap_r [2];
    assign idx = avs_address[9:2];
    assign wr = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[1:0] == 2'h0;
    assign wdiv = {wr && idx[7:4] == 4'h7, wr && idx[7:4] == 4'h6};
    assign tick = {tx_tick_o, rx_tick_o};
    // Shadow registers from completed writes.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sc <= '{default: 8'h00};
            ctrl_r <= 8'h00;
            div_r <= '{default: 16'h0000};
        end
        else if (wr)
        begin
            case (idx)
                8'h12, 8'h14, 8'h16, 8'h18: sc[(idx - 8'h12) >> 1] <= avs_writedata[7:0];
                8'h20: ctrl_r <= avs_writedata[7:0];
                8'h62: div_r[0][15:8] <= avs_writedata[7:0];
                8'h64: div_r[0][7:0] <= avs_writedata[7:0];
                8'h72: div_r[1][15:8] <= avs_writedata[7:0];
                8'h74: div_r[1][7:0] <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end
    // A divisor write makes the next tick interval uncertain, so it is skipped.
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < 4; i++)
            mexp_r[i] <= rx_char_i == sc[i];
        for (int i = 0; i < 2; i++)
        begin
            if (rst_i)
            begin
                chg_r[i] <= 1'b0;
                gap_r[i] <= 0;
            end
            else
            begin
                chg_r[i] <= tick[i] ? wdiv[i] : chg_r[i] | wdiv[i];
                gap_r[i] <= tick[i] ? 1 : gap_r[i] + 1;
            end
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    bus_one_wait_a: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
        |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait");
    reset_quiet_a: assert property ($fell(rst_i) |-> !rx_tick_o && !tx_tick_o
        && !tx_char_valid_o && !rx_stat_valid_o) else $error("busy after reset");
    stat_follow_a: assert property (rx_char_valid_i |=> rx_stat_valid_o
        && rx_stat_char_o == $past(rx_char_i)) else $error("no status");
    single_match_a: assert property (rx_char_valid_i && !ctrl_r[1]
        |=> rx_stat_match_o == mexp_r) else $error("match bits wrong");
    pair_hold_a: assert property (rx_char_valid_i && ctrl_r[1]
        && rx_char_i != sc[2] && rx_char_i != sc[3] |=> rx_stat_match_o == 4'h0)
        else $error("early pair match");
    send_start_a: assert property (wr && idx == 8'h22 && !tx_char_valid_o
        && avs_writedata[7:0] inside {8'h01, 8'h02, 8'h03} |=> tx_char_valid_o
        && tx_char_o == sc[$past(avs_writedata[1:0]) - 2'h1]) else $error("send start wrong");
    send_hold_a: assert property (tx_char_valid_o && !tx_char_ready_i
        |=> tx_char_valid_o && $stable(tx_char_o)) else $error("offer dropped");
    rx_period_a: assert property (rx_tick_o && !chg_r[0]
        |-> gap_r[0] == div_r[0]) else $error("rx period");
    tx_period_a: assert property (tx_tick_o && !chg_r[1]
        |-> gap_r[1] == div_r[1]) else $error("tx period");
    rx_idle_a: assert property (div_r[0] == 16'h0000 && !chg_r[0]
        |-> !rx_tick_o) else $error("rx tick at zero");
    tx_idle_a: assert property (div_r[1] == 16'h0000 && !chg_r[1]
        |-> !tx_tick_o) else $error("tx tick at zero");
    cover property (rx_stat_valid_o && rx_stat_match_o == abssc_pkg::MATCH_XON_PAIR);
    cover property (rx_stat_valid_o && rx_stat_match_o == abssc_pkg::MATCH_XOFF_PAIR);
    cover property (tx_char_valid_o && tx_char_ready_i && ctrl_r[0]);
endmodule : abssc_checker

bind abssc_top abssc_checker i_abssc_checker (.*);

// file: verif/abssc_line_partner.sv
// Model of the transmitter that takes special characters at a chosen pace.
module abssc_line_partner
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pace control
    input wire logic slow_i,
    // Character hand-over
    input wire logic [7:0] char_i,
    input wire logic valid_i,
    output logic ready_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] pace_r;
    logic [7:0] log_r [256];
    int n_acc;
    // In slow mode only every third cycle accepts a character.
    assign ready_o = !slow_i || pace_r == 2'h2;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pace_r <= 2'h0;
            n_acc <= 0;
        end
        else
        begin
            pace_r <= pace_r == 2'h2 ? 2'h0 : pace_r + 2'h1;
            if (valid_i && ready_o)
            begin
                log_r[n_acc[7:0]] <= char_i;
                n_acc <= n_acc + 1;
            end
        end
    end
endmodule : abssc_line_partner

// file: verif/test_async_baud_and_special_char.sv
// Self-checking bench of the block.
`define CHK(nm, got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("wrong value %s expected %0h seen %0h", nm, (exp), (got)); \
        end \
    end
module test_async_baud_and_special_char;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [7:0] idx; logic [7:0] d; logic [7:0] e; logic be;} abssc_row_t;
    logic clk_i, rst_i, avs_read, avs_write, avs_waitrequest, rx_char_valid_i, slow;
    logic rx_tick_o, tx_tick_o, rx_stat_valid_o, tx_char_valid_o, tx_char_ready_i;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable, rx_stat_match_o;
    logic [7:0] rx_char_i, rx_stat_char_o, tx_char_o;
    logic [1:0] tick;
    int n_fail = 0;
    int n_checks = 0;
    abssc_row_t rows [13] = '{
        '{8'h12, 8'h11, 8'h11, 1'b1}, '{8'h14, 8'h13, 8'h13, 1'b1},
        '{8'h16, 8'h91, 8'h91, 1'b1}, '{8'h18, 8'h93, 8'h93, 1'b1},
        '{8'h62, 8'h01, 8'h01, 1'b1}, '{8'h64, 8'h02, 8'h02, 1'b1},
        '{8'h72, 8'h00, 8'h00, 1'b1}, '{8'h74, 8'h03, 8'h03, 1'b1},
        '{8'h20, 8'h00, 8'h00, 1'b1}, '{8'h22, 8'h00, 8'h00, 1'b1},
        '{8'h24, 8'hFF, 8'h00, 1'b1}, '{8'h30, 8'h5A, 8'h00, 1'b1},
        '{8'h12, 8'hEE, 8'h11, 1'b0}};
    assign tick = {tx_tick_o, rx_tick_o};
    abssc_top i_abssc_top (.*);
    abssc_line_partner i_abssc_line_partner (.clk_i, .rst_i, .slow_i(slow), .char_i(tx_char_o),
        .valid_i(tx_char_valid_o), .ready_o(tx_char_ready_i));
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = !clk_i;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // One access, held until waitrequest is seen low.
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic b);
        @(posedge clk_i);
        avs_address <= {idx, 2'h0};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= {3'h7, b};
        do
            @(posedge clk_i);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic period(input int s, input int exp_p);
        int n;
        repeat (3)
        begin
            n = 0;
            do
            begin
                @(negedge clk_i);
                n++;
            end while (tick[s] !== 1'b1);
        end
        `CHK("tick period", n, exp_p)
    endtask : period
    task automatic quiet(input int s);
        int n = 0;
        repeat (40)
        begin
            @(negedge clk_i);
            if (tick[s] !== 1'b0)
                n++;
        end
        `CHK("ticks while zero", n, 0)
    endtask : quiet
    task automatic send(input logic [7:0] cmd, input logic [7:0] extra, input int n,
                        input logic [7:0] a, input logic [7:0] b);
        int base = i_abssc_line_partner.n_acc;
        bus(1'b1, 8'h22, cmd, 1'b1);
        if (extra !== 8'h00)
            bus(1'b1, 8'h22, extra, 1'b1);
        while (i_abssc_line_partner.n_acc < base + n)
            @(negedge clk_i);
        repeat (12) @(negedge clk_i);
        `CHK("chars sent", i_abssc_line_partner.n_acc - base, n)
        `CHK("first char", i_abssc_line_partner.log_r[base], a)
        if (n > 1)
            `CHK("second char", i_abssc_line_partner.log_r[base + 1], b)
    endtask : send
    task automatic rx(input logic [7:0] c, input logic [3:0] m);
        @(posedge clk_i);
        rx_char_i <= c;
        rx_char_valid_i <= 1'b1;
        @(posedge clk_i);
        rx_char_valid_i <= 1'b0;
        rx_char_i <= ~c;
        #1;
        `CHK("status strobe", rx_stat_valid_o, 1'b1)
        `CHK("status char", rx_stat_char_o, c)
        `CHK("status match", rx_stat_match_o, m)
    endtask : rx
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        test_done();
    end
    initial
    begin
        {avs_read, avs_write, rx_char_valid_i, slow, rst_i} = 5'h01;
        {avs_address, avs_writedata, avs_byteenable, rx_char_i} = 54'h0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        quiet(0);
        quiet(1);
        foreach (rows[i])
        begin
            bus(1'b0, rows[i].idx, 8'h00, 1'b1);
            `CHK("reset value", q, 32'h0)
        end
        foreach (rows[i])
            bus(1'b1, rows[i].idx, rows[i].d, rows[i].be);
        foreach (rows[i])
        begin
            bus(1'b0, rows[i].idx, 8'h00, 1'b1);
            `CHK("read back", q, {24'h0, rows[i].e})
        end
        period(0, 258);
        period(1, 3);
        bus(1'b1, 8'h74, 8'h00, 1'b1);
        repeat (8) @(negedge clk_i);
        quiet(1);
        send(8'h01, 8'h00, 1, 8'h11, 8'h00);
        send(8'h02, 8'h00, 1, 8'h13, 8'h00);
        send(8'h03, 8'h00, 1, 8'h91, 8'h00);
        bus(1'b1, 8'h20, 8'h01, 1'b1);
        slow <= 1'b1;
        send(8'h01, 8'h00, 2, 8'h11, 8'h91);
        send(8'h02, 8'h00, 2, 8'h13, 8'h93);
        send(8'h03, 8'h00, 1, 8'h91, 8'h00);
        send(8'h01, 8'h03, 2, 8'h11, 8'h91);
        rx(8'h11, 4'h1);
        rx(8'h13, 4'h2);
        rx(8'h91, 4'h4);
        rx(8'h93, 4'h8);
        rx(8'h20, 4'h0);
        bus(1'b1, 8'h20, 8'h02, 1'b1);
        rx(8'h11, 4'h0);
        rx(8'h91, 4'h5);
        rx(8'h13, 4'h0);
        rx(8'h93, 4'hA);
        rx(8'h11, 4'h0);
        rx(8'h20, 4'h0);
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 8'h64, 8'h00, 1'b1);
        `CHK("divisor after reset", q, 32'h0)
        test_done();
    end
endmodule : test_async_baud_and_special_char
